// [src/apsc_pkg.sv]
/*
 * Constants for the amplifier power-state controller: state codes, timing
 * figures and derived cycle counts.
 * Assumes a single 50 MHz clock and plain-port control and status bits.
 */
package apsc_pkg;

    typedef enum logic [2:0] {
        APSC_HW_SHDN,
        APSC_INIT,
        APSC_SW_SHDN,
        APSC_TURN_ON,
        APSC_ACTIVE,
        APSC_TURN_OFF
    } apsc_state_e;

    localparam int CLK_FREQ_HZ     = 50_000_000;
    localparam int CLK_PERIOD_NS   = 20;
    // Plain defaults: no figure is given for these times
    localparam int INIT_TIME_NS    = 1000;
    localparam int TURN_ON_TIME_NS = 2000;
    localparam int TURN_OFF_TIME_NS = 2000;
    localparam int INIT_CYCLES     = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TURN_ON_CYCLES  = TURN_ON_TIME_NS / CLK_PERIOD_NS;
    localparam int TURN_OFF_CYCLES = TURN_OFF_TIME_NS / CLK_PERIOD_NS;
    localparam int TIMER_W         = 16;

    localparam logic [5:0] FLAGS_RESET = 6'h00;
    localparam int FLAG_PWRUP      = 0;
    localparam int FLAG_PWRDN      = 1;
    localparam int FLAG_ANA_UV     = 2;
    localparam int FLAG_DIG_UV     = 3;
    localparam int FLAG_BAT_SHDN   = 4;
    localparam int FLAG_SPK_SHDN   = 5;
    localparam int FLAG_COUNT      = 6;

endpackage : apsc_pkg

// [src/apsc_flags.sv]
/*
 * Sticky event flags: set by hardware events, cleared by software strobes.
 * Assumes set and clear vectors are one-cycle pulses in the mclk domain.
 */
`timescale 1ns/1ps
module apsc_flags #(
    parameter int WIDTH = 6
) (
    input  wire logic             mclk,
    input  wire logic             srst,
    input  wire logic             wipe,
    input  wire logic [WIDTH-1:0] set_vec,
    input  wire logic [WIDTH-1:0] clr_vec,
    output logic      [WIDTH-1:0] flags_q
);
    logic [WIDTH-1:0] flags_d;

    initial begin
        if (WIDTH < 1) $error("apsc_flags: WIDTH must be positive");
    end

    // Set beats clear in the same cycle so no event is lost
    always_comb begin
        flags_d = wipe ? '0 : ((flags_q & ~clr_vec) | set_vec);
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            flags_q <= '0;
        end else begin
            flags_q <= flags_d;
        end
    end
endmodule : apsc_flags

// [src/apsc_power_ctrl.sv]
/*
 * Power-state controller: hardware shutdown, software shutdown and active,
 * with supply fault handling, auto-restart and sticky event flags.
 * Assumes supply comparator levels and control strobes are synchronous to mclk.
 */
`timescale 1ns/1ps
module apsc_power_ctrl
    import apsc_pkg::*;
#(
    parameter int INIT_CNT     = INIT_CYCLES,
    parameter int TURN_ON_CNT  = TURN_ON_CYCLES,
    parameter int TURN_OFF_CNT = TURN_OFF_CYCLES
) (
    input  wire logic       mclk,
    input  wire logic       srst,
    input  wire logic       reset_pin_n,
    input  wire logic       enable_wr,
    input  wire logic       enable_wdata,
    input  wire logic       global_reset_wr,
    input  wire logic       battery_fault_auto_restart,
    input  wire logic       speaker_supply_fault_auto_restart,
    input  wire logic       analog_supply_uv_ok,
    input  wire logic       analog_supply_pok,
    input  wire logic       digital_supply_uv_ok,
    input  wire logic       digital_supply_pok,
    input  wire logic       speaker_supply_uv_ok,
    input  wire logic       battery_uv_ok,
    input  wire logic [5:0] flag_clear,
    output logic            global_enable_q,
    output logic            control_port_en_q,
    output logic            blocks_en_q,
    output logic            regs_reset_q,
    output logic [2:0]      power_state_q,
    output logic            power_up_complete_flag,
    output logic            power_down_complete_flag,
    output logic            analog_supply_undervolt_flag,
    output logic            digital_supply_undervolt_flag,
    output logic            battery_undervolt_shutdown_flag,
    output logic            speaker_supply_undervolt_shutdown_flag
);
    ////////////////////////////////////////////////////////////////////////
    apsc_state_e          state_q, state_d;
    logic [TIMER_W-1:0]   timer_q, timer_d;
    logic                 en_q, en_d;
    logic                 bat_hold_q, bat_hold_d;
    logic                 spk_hold_q, spk_hold_d;
    logic [FLAG_COUNT-1:0] set_vec;
    logic [FLAG_COUNT-1:0] flags_q;
    logic                 wipe;
    logic                 en_now;
    logic                 supplies_ok;
    logic                 fault_any;
    logic                 hw_fault;

    initial begin
        if (INIT_CNT < 1 || TURN_ON_CNT < 1 || TURN_OFF_CNT < 1)
            $error("apsc_power_ctrl: counts must be at least one");
        if (INIT_CNT >= 2**TIMER_W || TURN_ON_CNT >= 2**TIMER_W
            || TURN_OFF_CNT >= 2**TIMER_W)
            $error("apsc_power_ctrl: counts exceed timer width");
    end

    function automatic logic [TIMER_W-1:0] to_timer(input int cnt);
        to_timer = TIMER_W'(cnt - 1);
    endfunction : to_timer

    ////////////////////////////////////////////////////////////////////////
    // Enable value as software would see it this cycle
    assign en_now      = enable_wr ? enable_wdata : en_q;
    assign supplies_ok = analog_supply_uv_ok && speaker_supply_uv_ok
                         && battery_uv_ok;
    // Loss of any supply that forces shutdown while powered
    assign fault_any   = !digital_supply_uv_ok || !speaker_supply_uv_ok
                         || !battery_uv_ok || !analog_supply_pok;
    assign hw_fault    = !reset_pin_n || !digital_supply_pok;

    always_comb begin
        state_d    = state_q;
        timer_d    = (timer_q != '0) ? timer_q - TIMER_W'(1) : timer_q;
        en_d       = en_now;
        bat_hold_d = bat_hold_q && !battery_uv_ok;
        spk_hold_d = spk_hold_q && !speaker_supply_uv_ok;
        set_vec    = '0;
        wipe       = 1'b0;

        if (hw_fault) begin
            // Digital power-ok loss is a complete reset, never reversible
            state_d    = APSC_HW_SHDN;
            en_d       = 1'b0;
            bat_hold_d = 1'b0;
            spk_hold_d = 1'b0;
            wipe       = 1'b1;
        end else if (global_reset_wr) begin
            state_d    = APSC_SW_SHDN;
            en_d       = 1'b0;
            bat_hold_d = 1'b0;
            spk_hold_d = 1'b0;
            wipe       = 1'b1;
        end else begin
            // Supply faults while powered end in shutdown without reversal
            if ((state_q == APSC_TURN_ON || state_q == APSC_ACTIVE) && fault_any) begin
                state_d = APSC_SW_SHDN;
                if (!analog_supply_uv_ok) set_vec[FLAG_ANA_UV] = 1'b1;
                if (!digital_supply_uv_ok) set_vec[FLAG_DIG_UV] = 1'b1;
                // Analog and digital faults leave enable set, so on their own they always restart
                if (!battery_uv_ok) begin
                    set_vec[FLAG_BAT_SHDN] = 1'b1;
                    if (battery_fault_auto_restart) bat_hold_d = 1'b1;
                    else en_d = 1'b0;
                end
                if (!speaker_supply_uv_ok) begin
                    set_vec[FLAG_SPK_SHDN] = 1'b1;
                    if (speaker_supply_fault_auto_restart) spk_hold_d = 1'b1;
                    else en_d = 1'b0;
                end
            end else begin
                case (state_q)
                    APSC_HW_SHDN: begin
                        if (speaker_supply_uv_ok && digital_supply_uv_ok) begin
                            state_d = APSC_INIT;
                            timer_d = to_timer(INIT_CNT);
                        end
                    end
                    APSC_INIT: begin
                        if (timer_q == '0) state_d = APSC_SW_SHDN;
                    end
                    APSC_SW_SHDN: begin
                        // Only enable moves to turn-on, and only when supplies hold;
                        // a standing fault blocks entry so turn-on cannot oscillate
                        if (en_now && supplies_ok && !fault_any && !bat_hold_q && !spk_hold_q) begin
                            state_d = APSC_TURN_ON;
                            timer_d = to_timer(TURN_ON_CNT);
                        end
                    end
                    APSC_TURN_ON: begin
                        if (!en_now) begin
                            state_d = APSC_TURN_OFF;
                            timer_d = to_timer(TURN_OFF_CNT);
                        end else if (timer_q == '0) begin
                            state_d = APSC_ACTIVE;
                            set_vec[FLAG_PWRUP] = 1'b1;
                        end
                    end
                    APSC_ACTIVE: begin
                        if (!en_now) begin
                            state_d = APSC_TURN_OFF;
                            timer_d = to_timer(TURN_OFF_CNT);
                        end
                    end
                    APSC_TURN_OFF: begin
                        if (en_now && supplies_ok && !fault_any) begin
                            state_d = APSC_TURN_ON;
                            timer_d = to_timer(TURN_ON_CNT);
                        end else if (timer_q == '0) begin
                            state_d = APSC_SW_SHDN;
                            set_vec[FLAG_PWRDN] = 1'b1;
                        end
                    end
                    default: begin
                        state_d = APSC_HW_SHDN;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            state_q    <= APSC_HW_SHDN;
            timer_q    <= '0;
            en_q       <= 1'b0;
            bat_hold_q <= 1'b0;
            spk_hold_q <= 1'b0;
        end else begin
            state_q    <= state_d;
            timer_q    <= timer_d;
            en_q       <= en_d;
            bat_hold_q <= bat_hold_d;
            spk_hold_q <= spk_hold_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    apsc_flags #(
        .WIDTH (FLAG_COUNT)
    ) u_flags (
        .mclk    (mclk),
        .srst    (srst),
        .wipe    (wipe),
        .set_vec (set_vec),
        .clr_vec (flag_clear),
        .flags_q (flags_q)
    );

    ////////////////////////////////////////////////////////////////////////
    // Outputs registered from next-state values so they track state_q
    always_ff @(posedge mclk) begin
        if (srst) begin
            global_enable_q   <= 1'b0;
            control_port_en_q <= 1'b0;
            blocks_en_q       <= 1'b0;
            regs_reset_q      <= 1'b1;
            power_state_q     <= 3'h0;
        end else begin
            global_enable_q   <= en_d;
            // Registers stay live and writable in software shutdown
            control_port_en_q <= (state_d != APSC_HW_SHDN) && (state_d != APSC_INIT);
            blocks_en_q       <= (state_d == APSC_TURN_ON) || (state_d == APSC_ACTIVE)
                                 || (state_d == APSC_TURN_OFF);
            regs_reset_q      <= wipe || (state_d == APSC_HW_SHDN);
            power_state_q     <= state_d;
        end
    end

    assign power_up_complete_flag                 = flags_q[FLAG_PWRUP];
    assign power_down_complete_flag               = flags_q[FLAG_PWRDN];
    assign analog_supply_undervolt_flag           = flags_q[FLAG_ANA_UV];
    assign digital_supply_undervolt_flag          = flags_q[FLAG_DIG_UV];
    assign battery_undervolt_shutdown_flag        = flags_q[FLAG_BAT_SHDN];
    assign speaker_supply_undervolt_shutdown_flag = flags_q[FLAG_SPK_SHDN];
endmodule : apsc_power_ctrl

// [tb/apsc_power_monitor.sv]
/* Assertion checker for the power-state controller.
   Assumes it is bound to apsc_power_ctrl and sees only its ports. */
`timescale 1ns/1ps
module apsc_power_monitor
    import apsc_pkg::*;
(
    input wire logic       mclk,
    input wire logic       srst,
    input wire logic       reset_pin_n,
    input wire logic       enable_wr,
    input wire logic       global_reset_wr,
    input wire logic       battery_fault_auto_restart,
    input wire logic       speaker_supply_fault_auto_restart,
    input wire logic       analog_supply_uv_ok,
    input wire logic       digital_supply_pok,
    input wire logic       speaker_supply_uv_ok,
    input wire logic       battery_uv_ok,
    input wire logic [5:0] flag_clear,
    input wire logic       global_enable_q,
    input wire logic       control_port_en_q,
    input wire logic       blocks_en_q,
    input wire logic [2:0] power_state_q,
    input wire logic       power_up_complete_flag,
    input wire logic       power_down_complete_flag,
    input wire logic       analog_supply_undervolt_flag,
    input wire logic       battery_undervolt_shutdown_flag,
    input wire logic       speaker_supply_undervolt_shutdown_flag
);
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    logic hw_ok;
    // Hardware and reset faults outrank every other cause
    assign hw_ok = digital_supply_pok && reset_pin_n && !global_reset_wr;
    ////////////////////////////////////////////////////////////////////////////
    a_hw_fault: assert property (!digital_supply_pok || !reset_pin_n |=>
        power_state_q == APSC_HW_SHDN) else $error("no hardware shutdown");
    a_shdn_blocks_off: assert property (power_state_q == APSC_SW_SHDN |->
        !blocks_en_q && control_port_en_q) else $error("blocks on in shutdown");
    a_active_entry: assert property (power_state_q == APSC_ACTIVE &&
        $past(power_state_q) != APSC_ACTIVE |-> $past(power_state_q) == APSC_TURN_ON)
        else $error("active entered from wrong state");
    a_supply_block: assert property (power_state_q == APSC_SW_SHDN &&
        !(analog_supply_uv_ok && speaker_supply_uv_ok && battery_uv_ok)
        |=> power_state_q != APSC_TURN_ON) else $error("turn-on with supply low");
    a_pwrup_flag: assert property (power_state_q == APSC_TURN_ON ##1
        power_state_q == APSC_ACTIVE |-> power_up_complete_flag)
        else $error("power-up flag missing");
    a_flag_hold: assert property (power_up_complete_flag && !flag_clear[0] && hw_ok
        |=> power_up_complete_flag) else $error("flag dropped by itself");
    a_flag_clear: assert property (power_down_complete_flag && flag_clear[1] &&
        power_state_q == APSC_ACTIVE |=> !power_down_complete_flag)
        else $error("flag not cleared");
    a_reset_bit: assert property (global_reset_wr && digital_supply_pok && reset_pin_n &&
        power_state_q inside {APSC_SW_SHDN, APSC_TURN_ON, APSC_ACTIVE, APSC_TURN_OFF}
        |=> power_state_q == APSC_SW_SHDN && !global_enable_q)
        else $error("global reset ignored");
    a_manual_fault: assert property (power_state_q == APSC_ACTIVE && !battery_uv_ok &&
        !battery_fault_auto_restart && hw_ok |=> ##[0:4]
        (!global_enable_q && battery_undervolt_shutdown_flag))
        else $error("manual fault handling wrong");
    a_auto_hold: assert property (power_state_q == APSC_ACTIVE && !speaker_supply_uv_ok &&
        speaker_supply_fault_auto_restart && battery_uv_ok && hw_ok && !enable_wr
        |=> global_enable_q && speaker_supply_undervolt_shutdown_flag)
        else $error("auto fault handling wrong");
    c_reverse: cover property (power_state_q == APSC_TURN_OFF ##1 power_state_q == APSC_TURN_ON);
    c_auto: cover property (speaker_supply_undervolt_shutdown_flag);
    c_analog: cover property (analog_supply_undervolt_flag);
endmodule : apsc_power_monitor

bind apsc_power_ctrl apsc_power_monitor i_mon (.*);

// [tb/apsc_host_model.sv]
/* Host processor model: writes control bits and drives the reset pin.
   Assumes the bench calls its tasks; all changes land on falling edges. */
`timescale 1ns/1ps
module apsc_host_model (
    input  wire logic  mclk,
    output logic       reset_pin_n,
    output logic       enable_wr,
    output logic       enable_wdata,
    output logic       global_reset_wr,
    output logic [5:0] flag_clear
);
    initial begin
        reset_pin_n = 1'b0;
        enable_wr = 1'b0;
        enable_wdata = 1'b0;
        global_reset_wr = 1'b0;
        flag_clear = 6'h00;
    end
    // Pin released last, after supplies are up
    task automatic power_on();
        @(negedge mclk) reset_pin_n = 1'b1;
    endtask : power_on
    // Audio clocks are taken as running before any enable
    task automatic wr_en(input logic v);
        @(negedge mclk) {enable_wr, enable_wdata} = {1'b1, v};
        @(negedge mclk) {enable_wr, enable_wdata} = {1'b0, ~v};
    endtask : wr_en
    task automatic wr_rst();
        @(negedge mclk) global_reset_wr = 1'b1;
        @(negedge mclk) global_reset_wr = 1'b0;
    endtask : wr_rst
    task automatic clr(input logic [5:0] m);
        @(negedge mclk) flag_clear = m;
        @(negedge mclk) flag_clear = 6'h00;
    endtask : clr
endmodule : apsc_host_model

// [tb/tb.sv]
/* Self-checking bench for the power-state controller.
   Assumes short turn-on, turn-off and init counts. */
`timescale 1ns/1ps
module tb;
    import apsc_pkg::*;
    logic mclk = 1'b0, srst = 1'b1, battery_fault_auto_restart;
    logic speaker_supply_fault_auto_restart = 1'b0, analog_supply_uv_ok = 1'b1;
    logic analog_supply_pok = 1'b1, digital_supply_uv_ok, digital_supply_pok = 1'b1;
    logic speaker_supply_uv_ok = 1'b1, battery_uv_ok = 1'b1;
    logic reset_pin_n, enable_wr, enable_wdata, global_reset_wr, global_enable_q;
    logic control_port_en_q, blocks_en_q, regs_reset_q, power_up_complete_flag;
    logic power_down_complete_flag, analog_supply_undervolt_flag;
    logic digital_supply_undervolt_flag, battery_undervolt_shutdown_flag;
    logic speaker_supply_undervolt_shutdown_flag;
    logic [5:0] flag_clear, flg;
    logic [2:0] power_state_q, last_st = 3'h0, exp_q[$];
    logic [31:0] lfsr = 32'h8be3;
    int n_mismatch = 0, n_checks = 0;
    assign flg = {speaker_supply_undervolt_shutdown_flag, battery_undervolt_shutdown_flag,
        digital_supply_undervolt_flag, analog_supply_undervolt_flag,
        power_down_complete_flag, power_up_complete_flag};
    always #10 mclk = ~mclk;
    apsc_host_model i_host (.*);
    apsc_power_ctrl #(.INIT_CNT(4), .TURN_ON_CNT(8), .TURN_OFF_CNT(8)) i_dut (.*);
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : nxt
    task automatic chk(input string nm, input logic [5:0] e, input logic [5:0] g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : conclude
    // Only settled states are noted, so transit states never need a note
    task automatic want(input logic [2:0] s);
        int i;
        exp_q.push_back(s);
        for (i = 0; i < 300 && power_state_q !== s; i++) @(negedge mclk);
        if (i == 300) begin
            chk("state wait", {3'h0, s}, {3'h0, power_state_q});
            conclude();
        end
        lfsr = nxt(lfsr);
        repeat (lfsr[1:0] + 2) @(negedge mclk);
    endtask : want
    always @(posedge mclk) begin
        #1;
        if (!srst && power_state_q !== last_st) begin
            last_st = power_state_q;
            if (last_st inside {APSC_HW_SHDN, APSC_SW_SHDN, APSC_ACTIVE})
                chk("state", exp_q.size() ? exp_q.pop_front() : 3'h7, last_st);
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {battery_fault_auto_restart, digital_supply_uv_ok} = 2'b01;
        repeat (5) @(negedge mclk);
        srst = 1'b0;
        i_host.power_on();
        want(APSC_SW_SHDN);
        chk("blocks", 6'h01, {4'h0, blocks_en_q, control_port_en_q});
        i_host.wr_en(1'b1);
        want(APSC_ACTIVE);
        chk("flags", 6'h01, flg);
        i_host.wr_en(1'b0);
        want(APSC_SW_SHDN);
        chk("flags", 6'h03, flg);
        $display("test enable cycle done");
        i_host.wr_en(1'b1);
        want(APSC_ACTIVE);
        i_host.wr_en(1'b0);
        i_host.wr_en(1'b1);
        want(APSC_ACTIVE);
        i_host.clr((lfsr[5:0] & 6'h3e) | 6'h02);
        chk("flags", 6'h01, flg);
        @(negedge mclk) battery_uv_ok = 1'b0;
        want(APSC_SW_SHDN);
        chk("manual", 6'h01, {4'h0, global_enable_q, flg[4]});
        battery_uv_ok = 1'b1;
        repeat (20) @(negedge mclk);
        chk("held", {3'h0, APSC_SW_SHDN}, {3'h0, power_state_q});
        i_host.wr_en(1'b1);
        want(APSC_ACTIVE);
        $display("test manual restart done");
        @(negedge mclk) {speaker_supply_fault_auto_restart, speaker_supply_uv_ok} = 2'b10;
        want(APSC_SW_SHDN);
        chk("auto", 6'h03, {4'h0, global_enable_q, flg[5]});
        speaker_supply_uv_ok = 1'b1;
        want(APSC_ACTIVE);
        @(negedge mclk) digital_supply_uv_ok = 1'b0;
        want(APSC_SW_SHDN);
        chk("digital", 6'h03, {4'h0, global_enable_q, flg[3]});
        digital_supply_uv_ok = 1'b1;
        want(APSC_ACTIVE);
        i_host.clr(6'h10);
        @(negedge mclk) {battery_fault_auto_restart, battery_uv_ok} = 2'b10;
        want(APSC_SW_SHDN);
        chk("auto battery", 6'h03, {4'h0, global_enable_q, flg[4]});
        battery_uv_ok = 1'b1;
        want(APSC_ACTIVE);
        {speaker_supply_fault_auto_restart, battery_fault_auto_restart} = 2'b00;
        $display("test auto restart done");
        i_host.wr_en(1'b0);
        want(APSC_SW_SHDN);
        for (int k = 0; k < 3; k++) begin
            {analog_supply_uv_ok, speaker_supply_uv_ok, battery_uv_ok} = ~(3'b100 >> k);
            i_host.wr_en(1'b1);
            repeat (20) @(negedge mclk);
            chk("blocked", {3'h0, APSC_SW_SHDN}, {3'h0, power_state_q});
            i_host.wr_rst();
            chk("reset bit", 6'h02, {4'h0, regs_reset_q, global_enable_q});
            {analog_supply_uv_ok, speaker_supply_uv_ok, battery_uv_ok} = 3'b111;
        end
        $display("test supply block done");
        i_host.wr_en(1'b1);
        want(APSC_ACTIVE);
        @(negedge mclk) {analog_supply_uv_ok, analog_supply_pok} = 2'b00;
        want(APSC_SW_SHDN);
        chk("analog", 6'h01, {5'h0, flg[2]});
        digital_supply_pok = 1'b0;
        want(APSC_HW_SHDN);
        chk("flags", 6'h00, flg);
        {digital_supply_pok, analog_supply_uv_ok, analog_supply_pok} = 3'b111;
        want(APSC_SW_SHDN);
        $display("test supply faults done");
        conclude();
    end
endmodule : tb
